// >>> shared/lddf_pkg.sv
// Purpose: shared constants and carriers of the load diagnostic flag block
// Assumes: 100 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   register layouts are the packed structs below, high bits first
package lddf_pkg;

    localparam int NCH    = 4;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CFG  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_GLB  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OUT  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_DIAG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h14;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing of the periodic led check
    localparam int CLK_PERIOD_NS = 10;
    localparam int LED_CHECK_US  = 1000;
    localparam int LED_CHECK_CYC = LED_CHECK_US * 1000 / CLK_PERIOD_NS;

    // analog comparator, supply monitor, direct input, reset and fail-safe status pins, all asynchronous
    typedef struct packed {
        logic [NCH-1:0] off_above;
        logic [NCH-1:0] bulb_low;
        logic [NCH-1:0] led_low;
        logic [NCH-1:0] direct_in;
        logic           otw_cmp;
        logic           clamp_cmp;
        logic           vdd_lost;
        logic           vdd_below_fail;
        logic           vpwr_uv;
        logic           batt_por;
        logic           both_por;
        logic           reset_pin_n;
        logic           fail_safe_status_pin;
    } lddf_pins_type;

    typedef struct packed {
        logic [NCH-1:0] sense_ratio_select;
        logic [NCH-1:0] led_open_load_select;
        logic [NCH-1:0] on_open_load_disable;
        logic [NCH-1:0] off_open_load_disable;
    } lddf_chcfg_type;

    typedef struct packed {
        logic [1:0] sense_channel_select;
        logic       current_sense_enable;
        logic       temp_feedback_enable;
        logic       pwm_enable;
        logic       vdd_fail_enable;
    } lddf_glb_type;

    typedef struct packed {
        logic [NCH-1:0] full_duty;
        logic [NCH-1:0] spi_on;
    } lddf_out_type;

    typedef struct packed {
        logic           undervoltage_flag;
        logic [NCH-1:0] on_open_load;
        logic [NCH-1:0] off_open_load;
    } lddf_stat_type;

    typedef struct packed {
        logic       temp;
        logic       current;
        logic [1:0] channel;
        logic       ratio;
    } lddf_sense_type;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } lddf_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } lddf_axi_rsp_type;

    typedef struct packed {
        lddf_axi_rsp_type  rsp;
        logic              aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic              w_have;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
    } lddf_axi_st_type;

    typedef struct packed {
        lddf_pins_type   pins_s1;
        lddf_pins_type   pins_s2;
        lddf_axi_st_type axi;
        lddf_chcfg_type  chcfg;
        lddf_glb_type    glb;
        lddf_out_type    outr;
        lddf_stat_type   stat;
        logic            over_temp_warning;
        logic [NCH-1:0]  ch_on;
        lddf_sense_type  sense;
        logic            retry_clear;
    } lddf_state_type;

endpackage

// >>> logic/lddf_on_timer.sv
// Purpose: per-channel on-time interval timer for the led open-load check
// Assumes: on_i comes from logic on clk_i
// Notes:   restarts whenever the channel turns off
`timescale 1ns/1ns
module lddf_on_timer #(
    parameter int CYC = lddf_pkg::LED_CHECK_CYC
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic on_i,
    output logic      settled_o,
    output logic      tick_o
);
    import lddf_pkg::*;

    localparam int CW = $clog2(CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          settled;
        logic          tick;
    } lddf_tmr_type;

    lddf_tmr_type st_q;
    lddf_tmr_type st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (!on_i)
        begin
            st_d = '0;
        end
        else if (st_q.cnt == CW'(CYC - 1))
        begin
            st_d.cnt     = '0;
            st_d.settled = 1'b1;
            st_d.tick    = 1'b1;
        end
        else
        begin
            st_d.cnt = st_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign settled_o = st_q.settled;
    assign tick_o    = st_q.tick;
endmodule

// >>> logic/lddf_top.sv
// Purpose: open-load, prewarning and supply-loss flag logic of a quad high-side switch
// Assumes: analog comparator pins are asynchronous; fail_safe_mode_i is on clk_i
// Notes:   registers over AXI4-Lite; status and diag clear on read
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module lddf_top #(
    parameter int LED_CYC = lddf_pkg::LED_CHECK_CYC
) (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire lddf_pkg::lddf_axi_req_type axi_req_i,
    output lddf_pkg::lddf_axi_rsp_type      axi_rsp_o,
    input  wire lddf_pkg::lddf_pins_type    pins_i,
    input  wire logic                       fail_safe_mode_i,
    output logic [lddf_pkg::NCH-1:0]        channel_on_o,
    output lddf_pkg::lddf_sense_type        sense_o,
    output logic                            autoretry_clear_o
);
    import lddf_pkg::*;

    lddf_state_type st_q;
    lddf_state_type st_d;
    logic [NCH-1:0] settled;
    logic [NCH-1:0] tick;

    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_tmr
            lddf_on_timer #(
                .CYC      (LED_CYC)
            ) u_tmr (
                .clk_i    (clk_i),
                .srst_i   (srst_i),
                .on_i     (st_q.ch_on[g]),
                .settled_o(settled[g]),
                .tick_o   (tick[g])
            );
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction

    // derived terms; all but rd_diag, on_set and wmerge also watched by the checks below
    lddf_pins_type  p;
    logic           cfg_clr;
    logic           rd_stat;
    logic           rd_diag;
    logic [NCH-1:0] off_cond;
    logic [NCH-1:0] on_cond;
    logic [NCH-1:0] on_set;
    logic [31:0]    wmerge;

    always_comb
    begin
        p        = st_q.pins_s2;
        // logic supply gone, enabled failure, both supplies or reset pin
        cfg_clr  = p.vdd_lost || (p.vdd_below_fail && st_q.glb.vdd_fail_enable)
                   || p.both_por || !p.reset_pin_n;
        rd_stat  = axi_req_i.arvalid && st_q.axi.rsp.arready
                   && axi_req_i.araddr == OFS_STAT;
        rd_diag  = axi_req_i.arvalid && st_q.axi.rsp.arready
                   && axi_req_i.araddr == OFS_DIAG;
        off_cond = ~st_q.ch_on & p.off_above;
        for (int c = 0; c < NCH; c++)
        begin
            // threshold choice per channel
            on_cond[c] = st_q.ch_on[c] && (st_q.chcfg.led_open_load_select[c]
                         ? p.led_low[c] : p.bulb_low[c]);
            // led mode only samples at the interval tick
            on_set[c]  = on_cond[c] && !st_q.chcfg.on_open_load_disable[c]
                         && (!st_q.chcfg.led_open_load_select[c]
                         || (tick[c] && settled[c] && st_q.outr.full_duty[c]
                         && st_q.glb.pwm_enable));
        end
    end

    always_comb
    begin
        st_d = st_q;
        // merged write word, sliced to each register's own width below
        wmerge = '0;
        st_d.pins_s1 = pins_i;
        st_d.pins_s2 = st_q.pins_s1;

        // write address and data are taken in either order
        if (axi_req_i.awvalid && st_q.axi.rsp.awready)
        begin
            st_d.axi.aw_have = 1'b1;
            st_d.axi.awaddr  = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && st_q.axi.rsp.wready)
        begin
            st_d.axi.w_have = 1'b1;
            st_d.axi.wdata  = axi_req_i.wdata;
            st_d.axi.wstrb  = axi_req_i.wstrb;
        end
        if (st_q.axi.aw_have && st_q.axi.w_have)
        begin
            st_d.axi.aw_have   = 1'b0;
            st_d.axi.w_have    = 1'b0;
            st_d.axi.rsp.bvalid = 1'b1;
            st_d.axi.rsp.bresp  = RESP_OKAY;
            unique case (st_q.axi.awaddr)
                OFS_CFG:
                begin
                    wmerge     = merge(32'(st_q.chcfg), st_q.axi.wdata, st_q.axi.wstrb);
                    st_d.chcfg = lddf_chcfg_type'(wmerge[$bits(lddf_chcfg_type)-1:0]);
                end
                OFS_GLB:
                begin
                    wmerge   = merge(32'(st_q.glb), st_q.axi.wdata, st_q.axi.wstrb);
                    st_d.glb = lddf_glb_type'(wmerge[$bits(lddf_glb_type)-1:0]);
                end
                OFS_OUT:
                begin
                    wmerge    = merge(32'(st_q.outr), st_q.axi.wdata, st_q.axi.wstrb);
                    st_d.outr = lddf_out_type'(wmerge[$bits(lddf_out_type)-1:0]);
                end
                default:
                    st_d.axi.rsp.bresp = RESP_SLVERR;
            endcase
        end
        if (st_q.axi.rsp.bvalid && axi_req_i.bready)
            st_d.axi.rsp.bvalid = 1'b0;

        // read data shows the value before any clear-on-read
        if (axi_req_i.arvalid && st_q.axi.rsp.arready)
        begin
            st_d.axi.rsp.rvalid = 1'b1;
            st_d.axi.rsp.rresp  = RESP_OKAY;
            unique case (axi_req_i.araddr)
                OFS_CFG:  st_d.axi.rsp.rdata = 32'(st_q.chcfg);
                OFS_GLB:  st_d.axi.rsp.rdata = 32'(st_q.glb);
                OFS_OUT:  st_d.axi.rsp.rdata = 32'(st_q.outr);
                OFS_STAT: st_d.axi.rsp.rdata = 32'(st_q.stat);
                OFS_DIAG: st_d.axi.rsp.rdata = 32'(st_q.over_temp_warning);
                OFS_LIVE: st_d.axi.rsp.rdata = 32'({fail_safe_mode_i, st_q.ch_on});
                default:
                begin
                    st_d.axi.rsp.rdata = '0;
                    st_d.axi.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_q.axi.rsp.rvalid && axi_req_i.rready)
            st_d.axi.rsp.rvalid = 1'b0;

        st_d.axi.rsp.awready = !st_d.axi.aw_have && !st_d.axi.rsp.bvalid;
        st_d.axi.rsp.wready  = !st_d.axi.w_have && !st_d.axi.rsp.bvalid;
        st_d.axi.rsp.arready = !st_d.axi.rsp.rvalid;

        // set wins over a read clear but cfg_clr wins over set; status reads clear status flags, off open load only while fail_safe_status_pin is high
        st_d.stat.off_open_load = (st_q.stat.off_open_load
            & ~({NCH{rd_stat && p.fail_safe_status_pin}} & ~off_cond))
            | (off_cond & ~st_q.chcfg.off_open_load_disable);
        st_d.stat.on_open_load = (st_q.stat.on_open_load
            & ~({NCH{rd_stat}} & ~on_cond)) | on_set;
        st_d.stat.undervoltage_flag = p.vpwr_uv
            || (st_q.stat.undervoltage_flag && !rd_stat);
        st_d.over_temp_warning = (p.otw_cmp && !fail_safe_mode_i)
            || (st_q.over_temp_warning && !rd_diag);

        // battery loss alone leaves configuration untouched
        if (cfg_clr)
        begin
            st_d.chcfg             = '0;
            st_d.glb               = '0;
            st_d.outr              = '0;
            st_d.stat              = '0;
            st_d.over_temp_warning = 1'b0;
        end

        // direct inputs stay in force without the logic supply
        if (p.batt_por)
            st_d.ch_on = '0;
        else if (p.clamp_cmp)
            st_d.ch_on = '1;
        else
            st_d.ch_on = st_q.outr.spi_on | p.direct_in;
        st_d.retry_clear = p.batt_por;

        st_d.sense.temp    = st_q.glb.temp_feedback_enable;
        st_d.sense.channel = st_q.glb.sense_channel_select;
        st_d.sense.ratio   = st_q.chcfg.sense_ratio_select[st_q.glb.sense_channel_select];
        // mirroring gated by on time and by fail-safe mode
        st_d.sense.current = st_q.glb.current_sense_enable
            && !st_q.glb.temp_feedback_enable
            && st_q.ch_on[st_q.glb.sense_channel_select]
            && !fail_safe_mode_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign axi_rsp_o         = st_q.axi.rsp;
    assign channel_on_o      = st_q.ch_on;
    assign sense_o           = st_q.sense;
    assign autoretry_clear_o = st_q.retry_clear;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence stat_read_s;
        rd_stat;
    endsequence

    sequence off_gone_s;
        st_q.stat.off_open_load[0] && !off_cond[0] && p.fail_safe_status_pin && !cfg_clr;
    endsequence

    clamp_all_on_a: assert property (
        p.clamp_cmp && !p.batt_por |=> channel_on_o == '1)
        else $error("clamp did not force channels on");

    por_off_a: assert property (
        p.batt_por |=> channel_on_o == '0 && autoretry_clear_o)
        else $error("battery reset did not turn channels off");

    off_set_a: assert property (
        off_cond[1] && !st_q.chcfg.off_open_load_disable[1] && !cfg_clr
        |=> st_q.stat.off_open_load[1])
        else $error("off open load not latched");

    off_disable_a: assert property (
        st_q.chcfg.off_open_load_disable[1] && off_cond[1] && !st_q.stat.off_open_load[1]
        |=> !st_q.stat.off_open_load[1])
        else $error("disabled channel raised off open load");

    off_clear_a: assert property (
        stat_read_s ##0 off_gone_s |=> !st_q.stat.off_open_load[0])
        else $error("off open load not cleared by read");

    on_hold_a: assert property (
        st_q.stat.on_open_load[3] && on_cond[3] && !cfg_clr
        |=> st_q.stat.on_open_load[3] [*1])
        else $error("on open load dropped while present");

    led_tick_a: assert property (
        st_q.chcfg.led_open_load_select[0] && !$past(st_q.stat.on_open_load[0])
        && st_q.stat.on_open_load[0] |-> $past(tick[0]) && $past(settled[0]))
        else $error("led check outside its interval");

    otw_fs_a: assert property (
        fail_safe_mode_i && !st_q.over_temp_warning |=> !st_q.over_temp_warning)
        else $error("prewarning set in fail-safe mode");

    sense_fs_a: assert property (
        fail_safe_mode_i ##1 fail_safe_mode_i |-> !sense_o.current)
        else $error("mirroring active in fail-safe mode");

    vdd_reset_a: assert property (
        p.vdd_lost |=> st_q.chcfg == '0 && st_q.glb == '0 && st_q.stat == '0)
        else $error("registers kept after logic supply loss");
endmodule

// >>> verification/lddf_mcu_model.sv
// Purpose: bus master standing in for the microcontroller
// Assumes: axi4-lite slave on clk_i, one transfer at a time
// Notes:   hang_o rises when an answer never comes
`timescale 1ns/1ns
module lddf_mcu_model (
    input  wire logic                       clk_i,
    input  wire lddf_pkg::lddf_axi_rsp_type axi_rsp_i,
    output lddf_pkg::lddf_axi_req_type      axi_req_o,
    output logic                            hang_o
);
    import lddf_pkg::*;
    initial
    begin
        axi_req_o = '0;
        hang_o    = 1'b0;
    end
    // address and data offered together, each dropped at its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ok;
        ok = 1'b0;
        r = 2'h0;
        @(posedge clk_i);
        axi_req_o.awvalid <= 1'b1;
        axi_req_o.awaddr  <= a;
        axi_req_o.wvalid  <= 1'b1;
        axi_req_o.wdata   <= d;
        axi_req_o.wstrb   <= 4'hf;
        axi_req_o.bready  <= 1'b1;
        for (int n = 0; n < 64 && !ok; n++)
        begin
            @(posedge clk_i);
            if (axi_req_o.awvalid && axi_rsp_i.awready)
                axi_req_o.awvalid <= 1'b0;
            if (axi_req_o.wvalid && axi_rsp_i.wready)
                axi_req_o.wvalid <= 1'b0;
            if (axi_rsp_i.bvalid)
            begin
                ok = 1'b1;
                r = axi_rsp_i.bresp;
                axi_req_o.bready <= 1'b0;
            end
        end
        hang_o <= !ok;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ok;
        ok = 1'b0;
        d = 32'h0;
        r = 2'h0;
        @(posedge clk_i);
        axi_req_o.arvalid <= 1'b1;
        axi_req_o.araddr  <= a;
        axi_req_o.rready  <= 1'b1;
        for (int n = 0; n < 64 && !ok; n++)
        begin
            @(posedge clk_i);
            if (axi_req_o.arvalid && axi_rsp_i.arready)
                axi_req_o.arvalid <= 1'b0;
            if (axi_rsp_i.rvalid)
            begin
                ok = 1'b1;
                d = axi_rsp_i.rdata;
                r = axi_rsp_i.rresp;
                axi_req_o.rready <= 1'b0;
            end
        end
        hang_o <= !ok;
    endtask
endmodule

// >>> verification/tb_lddf_top.sv
// Purpose: self-checking bench of the load diagnostic flag block
// Assumes: pin changes act within three edges
// Notes:   led interval shortened to LED cycles
`timescale 1ns/1ns
module tb_lddf_top;
    import lddf_pkg::*;
    localparam int LED = 8;
    logic             clk_i;
    logic             srst_i;
    lddf_axi_req_type req;
    lddf_axi_rsp_type rsp;
    lddf_pins_type    pins;
    logic             fsm;
    logic [NCH-1:0]   ch_on;
    lddf_sense_type   sense;
    logic             arc;
    logic             hang;
    int               mismatches;
    int               tests_run;
    lddf_top #(.LED_CYC(LED)) dut (.clk_i(clk_i), .srst_i(srst_i), .axi_req_i(req),
        .axi_rsp_o(rsp), .pins_i(pins), .fail_safe_mode_i(fsm), .channel_on_o(ch_on),
        .sense_o(sense), .autoretry_clear_o(arc));
    lddf_mcu_model mcu (.clk_i(clk_i), .axi_rsp_i(rsp), .axi_req_o(req), .hang_o(hang));
    always #5 clk_i = ~clk_i;
    task automatic summarize;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i)
        if (hang === 1'b1)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, hang, 1'b0);
            summarize();
        end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic [1:0] r;
        mcu.wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        mcu.rd(a, d, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        chk(d & m, e);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        rd(OFS_CFG, 32'hffff, 32'h0);
        rd(OFS_GLB, 32'h3f, 32'h0);
        rd(OFS_STAT, 32'h1ff, 32'h0);
        mcu.rd(8'h40, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        wr(OFS_DIAG, 32'h1, RESP_SLVERR);
    endtask
    task automatic t_off;
        wr(OFS_CFG, 32'h2);
        pins.fail_safe_status_pin <= 1'b0;
        pins.off_above <= 4'hf;
        wait_n(6);
        pins.off_above <= 4'h0;
        wait_n(6);
        rd(OFS_STAT, 32'hf, 32'hd);
        rd(OFS_STAT, 32'hf, 32'hd);
        pins.fail_safe_status_pin <= 1'b1;
        wait_n(6);
        rd(OFS_DIAG, 32'h1, 32'h0);
        rd(OFS_STAT, 32'hf, 32'hd);
        rd(OFS_STAT, 32'hf, 32'h0);
    endtask
    task automatic t_on;
        wr(OFS_CFG, 32'h80);
        wr(OFS_OUT, 32'hf);
        pins.led_low <= 4'hf;
        wait_n(6);
        rd(OFS_STAT, 32'hf0, 32'h0);
        pins.bulb_low <= 4'hf;
        wait_n(6);
        chk({28'h0, ch_on}, 32'hf);
        rd(OFS_STAT, 32'hf0, 32'h70);
        rd(OFS_STAT, 32'hf0, 32'h70);
        pins.bulb_low <= 4'h0;
        pins.led_low <= 4'h0;
        wait_n(6);
        rd(OFS_STAT, 32'hf0, 32'h70);
        rd(OFS_STAT, 32'hf0, 32'h0);
    endtask
    task automatic t_led;
        wr(OFS_CFG, 32'h100);
        wr(OFS_GLB, 32'h0);
        wr(OFS_OUT, 32'h11);
        pins.led_low <= 4'h1;
        wait_n(4 * LED);
        rd(OFS_STAT, 32'hf0, 32'h0);
        wr(OFS_GLB, 32'h2);
        wait_n(4 * LED);
        rd(OFS_STAT, 32'hf0, 32'h10);
        pins.led_low <= 4'h0;
        wr(OFS_OUT, 32'h0);
        wait_n(6);
        rd(OFS_STAT, 32'hf0, 32'h10);
        rd(OFS_STAT, 32'hf0, 32'h0);
    endtask
    task automatic t_sense;
        wr(OFS_CFG, 32'h4000);
        wr(OFS_GLB, 32'h28);
        wait_n(6);
        chk({31'h0, sense.current}, 32'h0);
        wr(OFS_OUT, 32'h4);
        wait_n(6);
        chk({27'h0, sense}, 32'hd);
        fsm <= 1'b1;
        pins.otw_cmp <= 1'b1;
        wait_n(4);
        chk({31'h0, sense.current}, 32'h0);
        rd(OFS_LIVE, 32'h1f, 32'h14);
        pins.otw_cmp <= 1'b0;
        wait_n(3);
        fsm <= 1'b0;
        rd(OFS_DIAG, 32'h1, 32'h0);
        wr(OFS_GLB, 32'h2c);
        wait_n(6);
        chk({27'h0, sense} & 32'h18, 32'h10);
        wr(OFS_OUT, 32'h0);
        wr(OFS_GLB, 32'h0);
    endtask
    task automatic t_otw;
        pins.otw_cmp <= 1'b1;
        wait_n(6);
        pins.otw_cmp <= 1'b0;
        wait_n(6);
        rd(OFS_DIAG, 32'h1, 32'h1);
        rd(OFS_DIAG, 32'h1, 32'h0);
    endtask
    task automatic t_chan;
        pins.vdd_lost <= 1'b1;
        pins.direct_in <= 4'h5;
        wait_n(6);
        chk({28'h0, ch_on}, 32'h5);
        pins.clamp_cmp <= 1'b1;
        wait_n(6);
        chk({28'h0, ch_on}, 32'hf);
        wr(OFS_OUT, 32'h0);
        pins.batt_por <= 1'b1;
        wait_n(6);
        chk({27'h0, arc, ch_on}, 32'h10);
        pins.batt_por <= 1'b0;
        pins.clamp_cmp <= 1'b0;
        wait_n(6);
        chk({28'h0, ch_on}, 32'h5);
        pins.direct_in <= 4'h0;
        pins.vdd_lost <= 1'b0;
        wait_n(6);
    endtask
    task automatic pulse_fail;
        pins.vdd_below_fail <= 1'b1;
        wait_n(6);
        pins.vdd_below_fail <= 1'b0;
        wait_n(4);
    endtask
    task automatic t_supply;
        wr(OFS_CFG, 32'h1234);
        pins.vpwr_uv <= 1'b1;
        wait_n(6);
        rd(OFS_CFG, 32'hffff, 32'h1234);
        rd(OFS_STAT, 32'h100, 32'h100);
        pins.vpwr_uv <= 1'b0;
        wait_n(6);
        rd(OFS_STAT, 32'h100, 32'h100);
        rd(OFS_STAT, 32'h100, 32'h0);
        pulse_fail();
        rd(OFS_CFG, 32'hffff, 32'h1234);
        wr(OFS_GLB, 32'h1);
        pulse_fail();
        rd(OFS_CFG, 32'hffff, 32'h0);
        rd(OFS_GLB, 32'h3f, 32'h0);
        wr(OFS_CFG, 32'hf);
        pins.reset_pin_n <= 1'b0;
        wait_n(6);
        pins.reset_pin_n <= 1'b1;
        wait_n(4);
        rd(OFS_CFG, 32'hffff, 32'h0);
        wr(OFS_CFG, 32'hf);
        pins.otw_cmp <= 1'b1;
        wait_n(6);
        pins.otw_cmp <= 1'b0;
        pins.both_por <= 1'b1;
        wait_n(6);
        pins.both_por <= 1'b0;
        wait_n(4);
        rd(OFS_CFG, 32'hffff, 32'h0);
        rd(OFS_DIAG, 32'h1, 32'h0);
        pins.off_above <= 4'hf;
        wait_n(6);
        pins.off_above <= 4'h0;
        wait_n(6);
        rd(OFS_STAT, 32'hf, 32'hf);
    endtask
    initial
    begin
        clk_i = 1'b0;
        srst_i = 1'b1;
        fsm = 1'b0;
        mismatches = 0;
        tests_run = 0;
        pins = '0;
        pins.reset_pin_n = 1'b1;
        pins.fail_safe_status_pin = 1'b1;
        wait_n(4);
        srst_i <= 1'b0;
        wait_n(2);
        t_reset();
        t_off();
        t_on();
        t_led();
        t_sense();
        t_otw();
        t_chan();
        t_supply();
        summarize();
    end
endmodule
